// [logic/scr_pkg.sv]
/*
  Package for the system control register group: register indices,
  field positions, reset values, selector codes, unlock keys and the
  carrier struct for the internal sources that can be routed to the pins.
  Assumes a host-side serial front end that presents decoded word accesses.
*/
package scr_pkg;

  // register indices as seen on the host register port
  localparam logic [7:0] ADDR_BUS_TARGET = 8'h09;
  localparam logic [7:0] ADDR_PIN_ALT = 8'h0B;
  localparam logic [7:0] ADDR_UNLOCK = 8'h0D;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h0F;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_SLOT_FIFO = 8'h11;

  // field positions
  localparam int PIN_ZERO_SEL_LSB = 0;
  localparam int PIN_ONE_SEL_LSB = 8;
  localparam int SEL_WIDTH = 5;
  localparam int TARGET_LSB = 1;
  localparam int TARGET_WIDTH = 7;
  localparam int KEY_BYTE_LSB = 8;
  localparam int READBACK_SEL_BIT = 13;
  localparam int OVERFLOW_GUARD_BIT = 12;
  localparam int SOFT_RESET_BIT = 0;

  // values after reset
  localparam logic [15:0] UNLOCK_RESET = 16'h0000;
  localparam logic [4:0] SEL_RESET = 5'h00;
  localparam logic [6:0] TARGET_RESET = 7'h64;
  localparam logic [15:0] SLOT_FIFO_RESET = 16'h1000;

  // key written with a new bus target address
  localparam logic [7:0] TARGET_WRITE_KEY = 8'hAD;

  // unlock keys
  localparam logic [15:0] UNLOCK_ALWAYS = 16'h04AD;
  localparam logic [15:0] UNLOCK_PIN_ZERO = 16'h44AD;
  localparam logic [15:0] UNLOCK_PIN_ONE = 16'h84AD;
  localparam logic [15:0] UNLOCK_BOTH = 16'hC4AD;

  // pin alternate-function selector codes
  localparam logic [4:0] SEL_LEGACY = 5'h00;
  localparam logic [4:0] SEL_INTERRUPT = 5'h01;
  localparam logic [4:0] SEL_SLOT_WINDOW = 5'h02;
  localparam logic [4:0] SEL_PULSE_A = 5'h05;
  localparam logic [4:0] SEL_PULSE_B = 5'h06;
  localparam logic [4:0] SEL_PULSE_AB = 5'h07;
  localparam logic [4:0] SEL_DATA_A = 5'h0C;
  localparam logic [4:0] SEL_DATA_B = 5'h0D;
  localparam logic [4:0] SEL_DATA_AB = 5'h0E;
  localparam logic [4:0] SEL_TOGGLE = 5'h0F;
  localparam logic [4:0] SEL_LOW = 5'h10;
  localparam logic [4:0] SEL_HIGH = 5'h11;
  localparam logic [4:0] SEL_OSC = 5'h13;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_PROGRAM = 2'h1,
    MODE_NORMAL = 2'h2
  } scr_mode_type;

  // internal events and levels that the pins can carry
  typedef struct packed {
    logic legacy;
    logic interrupt;
    logic slotWindow;
    logic pulseA;
    logic pulseB;
    logic dataA;
    logic dataB;
    logic sampleTick;
    logic osc32k;
  } scr_pin_sources_type;

endpackage

// [logic/scr_pin_mux.sv]
/*
  One general-purpose pin output multiplexer with its half-rate toggle.
  Assumes sources are synchronous to clock; unlisted codes drive low.
*/
`timescale 1ns/10ps
`default_nettype none
module scr_pin_mux
  import scr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic softReset,
  // selection and sources
  input wire logic [4:0] select,
  input wire scr_pin_sources_type sources,
  // pin level
  output logic pinLevel
);

  logic toggleReg;
  logic pinNext;

  always_ff @(posedge clock) begin
    if (!rst_n || softReset) begin
      toggleReg <= 1'b0;
    end else if (sources.sampleTick) begin
      toggleReg <= ~toggleReg; // [RULE5]
    end
  end

  always_comb begin
    case (select)
      SEL_LEGACY: pinNext = sources.legacy; // [RULE1]
      SEL_INTERRUPT: pinNext = sources.interrupt; // [RULE1]
      SEL_SLOT_WINDOW: pinNext = sources.slotWindow; // [RULE2]
      SEL_PULSE_A: pinNext = sources.pulseA; // [RULE3]
      SEL_PULSE_B: pinNext = sources.pulseB; // [RULE3]
      SEL_PULSE_AB: pinNext = sources.pulseA | sources.pulseB; // [RULE3]
      SEL_DATA_A: pinNext = sources.dataA; // [RULE4]
      SEL_DATA_B: pinNext = sources.dataB; // [RULE4]
      SEL_DATA_AB: pinNext = sources.dataA | sources.dataB; // [RULE4]
      SEL_TOGGLE: pinNext = toggleReg; // [RULE5]
      SEL_LOW: pinNext = 1'b0; // [RULE6]
      SEL_HIGH: pinNext = 1'b1; // [RULE6]
      SEL_OSC: pinNext = sources.osc32k; // [RULE6]
      // unsupported codes: quiet low rather than an undefined level
      default: pinNext = 1'b0;
    endcase
  end

  // registered so the pin never glitches between sources
  always_ff @(posedge clock) begin
    if (!rst_n || softReset) begin
      pinLevel <= 1'b0;
    end else begin
      pinLevel <= pinNext;
    end
  end

endmodule
`default_nettype wire

// [logic/scr_control_regs.sv]
/*
  System control register group: pin routing selectors, bus target
  address unlock, self-clearing soft reset, operating mode and slot FIFO
  options. Assumes the serial front end delivers one-cycle read and
  write strobes with a register index and 16-bit data, synchronous to clock.
*/
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// RULE1: selector 0x1 routes configured interrupt; 0x0 legacy
// RULE2: selector 0x2 spans first to last slot
// RULE3: selectors 0x5-0x7 give slot pulse timing
// RULE4: selectors 0xC-0xE flag output data cycles
// RULE5: selector 0xF toggles pin every sample
// RULE6: 0x10 low, 0x11 high, 0x13 oscillator
// RULE7: key 0x04AD always permits address change
// RULE8: other keys permit change on pin levels
// RULE9: soft reset bit resets, then self-clears
// RULE10: soft reset write acknowledged, then all defaults
// RULE11: mode field: standby, program, normal
// RULE12: bit 13 selects block sum or average
// RULE13: bit 12 guards FIFO overflow, default set
// RULE14: host writes 0xAD key with new address
// RULE15: unlisted unlock values keep address locked
module scr_control_regs
  import scr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // host register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWriteData,
  output logic [15:0] regReadData,
  output logic regWriteAck,
  output logic regReadValid,
  // sources routed to the pins and pin levels seen on the pads
  input wire scr_pin_sources_type pinZeroSources,
  input wire scr_pin_sources_type pinOneSources,
  input wire logic pinZeroPad,
  input wire logic pinOnePad,
  // pin outputs
  output logic generalPinZero,
  output logic generalPinOne,
  // configuration towards the core
  output scr_mode_type operatingMode,
  output logic extendedReadbackSelect,
  output logic queueOverflowGuard,
  output logic [6:0] busTargetAddress,
  output logic softResetActive
);

  logic [15:0] unlockReg;
  logic [4:0] pinZeroSelReg;
  logic [4:0] pinOneSelReg;
  logic [15:0] slotFifoReg;
  logic [6:0] targetReg;
  scr_mode_type modeReg;
  logic softResetReg;
  logic clearAll;
  logic changeAllowed;
  logic [15:0] readNext;
  logic [1:0] pinLevels;
  logic [4:0] pinSel [2];
  scr_pin_sources_type pinSrc [2];

  // soft reset takes effect one cycle after its write was acknowledged
  assign clearAll = !rst_n || softResetReg; // [RULE10]

  always_ff @(posedge clock) begin
    if (!rst_n || softResetReg) begin
      softResetReg <= 1'b0; // [RULE9]
    end else if (regWrite && regAddr == ADDR_SOFT_RESET) begin
      softResetReg <= regWriteData[SOFT_RESET_BIT]; // [RULE9]
    end
  end

  // every write is acknowledged, the reset write included
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      regWriteAck <= 1'b0;
    end else begin
      regWriteAck <= regWrite; // [RULE10]
    end
  end

  always_ff @(posedge clock) begin
    if (clearAll) begin
      unlockReg <= UNLOCK_RESET;
    end else if (regWrite && regAddr == ADDR_UNLOCK) begin
      unlockReg <= regWriteData;
    end
  end

  // pad levels count only at the address write itself; later changes do not relock
  always_comb begin
    case (unlockReg)
      UNLOCK_ALWAYS: changeAllowed = 1'b1; // [RULE7]
      UNLOCK_PIN_ZERO: changeAllowed = pinZeroPad; // [RULE8]
      UNLOCK_PIN_ONE: changeAllowed = pinOnePad; // [RULE8]
      UNLOCK_BOTH: changeAllowed = pinZeroPad && pinOnePad; // [RULE8]
      default: changeAllowed = 1'b0; // [RULE15]
    endcase
  end

  // the key byte guards against a stray write reaching the address
  always_ff @(posedge clock) begin
    if (clearAll) begin
      targetReg <= TARGET_RESET;
    end else if (regWrite && regAddr == ADDR_BUS_TARGET && changeAllowed &&
                 regWriteData[KEY_BYTE_LSB +: 8] == TARGET_WRITE_KEY) begin
      targetReg <= regWriteData[TARGET_LSB +: TARGET_WIDTH]; // [RULE14]
    end
  end

  always_ff @(posedge clock) begin
    if (clearAll) begin
      pinZeroSelReg <= SEL_RESET;
      pinOneSelReg <= SEL_RESET;
    end else if (regWrite && regAddr == ADDR_PIN_ALT) begin
      pinZeroSelReg <= regWriteData[PIN_ZERO_SEL_LSB +: SEL_WIDTH];
      pinOneSelReg <= regWriteData[PIN_ONE_SEL_LSB +: SEL_WIDTH];
    end
  end

  always_ff @(posedge clock) begin
    if (clearAll) begin
      modeReg <= MODE_STANDBY; // [RULE10]
    end else if (regWrite && regAddr == ADDR_MODE) begin
      case (regWriteData[1:0])
        2'h0: modeReg <= MODE_STANDBY; // [RULE11]
        2'h1: modeReg <= MODE_PROGRAM; // [RULE11]
        2'h2: modeReg <= MODE_NORMAL; // [RULE11]
        // code 3 is undefined: keep the mode already running
        default: modeReg <= modeReg;
      endcase
    end
  end

  // bits 15:14 are reserved and stay zero
  always_ff @(posedge clock) begin
    if (clearAll) begin
      slotFifoReg <= SLOT_FIFO_RESET; // [RULE13]
    end else if (regWrite && regAddr == ADDR_SLOT_FIFO) begin
      slotFifoReg <= {2'h0, regWriteData[13:0]};
    end
  end

  always_comb begin
    case (regAddr)
      ADDR_BUS_TARGET: readNext = {8'h00, targetReg, 1'b0};
      ADDR_PIN_ALT: readNext = {3'h0, pinOneSelReg, 3'h0, pinZeroSelReg};
      ADDR_UNLOCK: readNext = unlockReg;
      ADDR_SOFT_RESET: readNext = {15'h0000, softResetReg};
      ADDR_MODE: readNext = {14'h0000, modeReg};
      ADDR_SLOT_FIFO: readNext = slotFifoReg;
      default: readNext = 16'h0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      regReadData <= 16'h0000;
      regReadValid <= 1'b0;
    end else begin
      regReadValid <= regRead;
      if (regRead) begin
        regReadData <= readNext;
      end
    end
  end

  // configuration outputs, each from its own flop
  always_ff @(posedge clock) begin
    if (clearAll) begin
      operatingMode <= MODE_STANDBY;
      extendedReadbackSelect <= SLOT_FIFO_RESET[READBACK_SEL_BIT];
      queueOverflowGuard <= SLOT_FIFO_RESET[OVERFLOW_GUARD_BIT];
      busTargetAddress <= TARGET_RESET;
    end else begin
      operatingMode <= modeReg; // [RULE11]
      extendedReadbackSelect <= slotFifoReg[READBACK_SEL_BIT]; // [RULE12]
      queueOverflowGuard <= slotFifoReg[OVERFLOW_GUARD_BIT]; // [RULE13]
      busTargetAddress <= targetReg;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      softResetActive <= 1'b0;
    end else begin
      softResetActive <= softResetReg; // [RULE9]
    end
  end

  // both pins share one multiplexer design, index zero and one
  assign pinSel[0] = pinZeroSelReg;
  assign pinSel[1] = pinOneSelReg;
  assign pinSrc[0] = pinZeroSources;
  assign pinSrc[1] = pinOneSources;

  for (genvar i = 0; i < 2; i++) begin : gen_pin_mux
    // soft reset also clears the toggle, so a restart begins low
    scr_pin_mux pinMux (
      .clock(clock),
      .rst_n(rst_n),
      .softReset(softResetReg),
      .select(pinSel[i]),
      .sources(pinSrc[i]),
      .pinLevel(pinLevels[i])
    );
  end

  // pin outputs are the multiplexers' own flops, passed straight out
  assign generalPinZero = pinLevels[0];
  assign generalPinOne = pinLevels[1];

endmodule
`default_nettype wire

// [dv/scr_control_regs_props.sv]
/* checker for the control register group
   sees only the top ports; bound to scr_control_regs */
`timescale 1ns/10ps
`default_nettype none
module scr_control_regs_props
  import scr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // host port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWriteData,
  input wire logic regWriteAck,
  input wire logic regReadValid,
  // outputs
  input wire logic generalPinZero,
  input wire logic generalPinOne,
  input wire scr_mode_type operatingMode,
  input wire logic extendedReadbackSelect,
  input wire logic queueOverflowGuard,
  input wire logic [6:0] busTargetAddress,
  input wire logic softResetActive
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic swr;
  logic pinWr;
  assign swr = regWrite && regAddr == ADDR_SOFT_RESET && regWriteData[0];
  assign pinWr = regWrite && regAddr == ADDR_PIN_ALT;
  sequence resetPulse;
    ##2 softResetActive ##1 !softResetActive;
  endsequence
  chk_write_ack: assert property (regWriteAck == $past(regWrite))
    else $error("write ack does not follow write strobe");
  chk_read_valid: assert property (regReadValid == $past(regRead))
    else $error("read valid does not follow read strobe");
  chk_mode_follow: assert property (regWrite && regAddr == ADDR_MODE &&
    regWriteData[1:0] != 2'h3 |-> ##2 operatingMode == $past(regWriteData[1:0], 2))
    else $error("operating mode not taken from write");
  chk_pin_high: assert property (pinWr && regWriteData[4:0] == SEL_HIGH
    |-> ##2 generalPinZero) else $error("pin zero not held high");
  chk_pin_low: assert property (pinWr && regWriteData[12:8] == SEL_LOW
    |-> ##2 !generalPinOne) else $error("pin one not held low");
  chk_soft_pulse: assert property (swr |-> resetPulse)
    else $error("soft reset pulse wrong");
  chk_reset_defaults: assert property (softResetActive |=>
    operatingMode == MODE_STANDBY && queueOverflowGuard && !extendedReadbackSelect
    && busTargetAddress == TARGET_RESET) else $error("defaults not restored");
  chk_fifo_bits: assert property (regWrite && regAddr == ADDR_SLOT_FIFO |-> ##2
    queueOverflowGuard == $past(regWriteData[12], 2)
    && extendedReadbackSelect == $past(regWriteData[13], 2))
    else $error("slot fifo option bits wrong");
endmodule
bind scr_control_regs scr_control_regs_props chk_inst (.clock(clock), .rst_n(rst_n),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
  .regWriteAck(regWriteAck), .regReadValid(regReadValid), .generalPinZero(generalPinZero),
  .generalPinOne(generalPinOne), .operatingMode(operatingMode),
  .extendedReadbackSelect(extendedReadbackSelect), .queueOverflowGuard(queueOverflowGuard),
  .busTargetAddress(busTargetAddress), .softResetActive(softResetActive));
`default_nettype wire

// [dv/scr_host_model.sv]
/* host processor model for the register port
   assumes the bench calls its tasks off the clock edge */
`timescale 1ns/10ps
`default_nettype none
module scr_host_model (
  // clock
  input wire logic clock,
  // register port
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [15:0] regWriteData,
  input wire logic [15:0] regReadData
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWriteData = 16'h0000;
  end
  // callers also give unlisted codes and keys, or omit the key byte
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    @(posedge clock);
    #1;
    regWrite = 1'b0;
    // released data no longer shows the last value
    regWriteData = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    #1;
    regAddr = a;
    regRead = 1'b1;
    @(posedge clock);
    #1;
    d = regReadData;
    regRead = 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/scr_control_regs_tb_top.sv]
/* self-checking bench for the control register group
   drives sources and pads; the host model drives the port */
`timescale 1ns/10ps
`default_nettype none
module scr_control_regs_tb_top;
  import scr_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, pinZeroPad = 1'b0, pinOnePad = 1'b0;
  logic regWrite, regRead, regWriteAck, regReadValid, generalPinZero, generalPinOne;
  logic extendedReadbackSelect, queueOverflowGuard, softResetActive;
  logic [7:0] regAddr, a;
  logic [15:0] regWriteData, regReadData, d, e, r;
  logic [6:0] busTargetAddress;
  logic [8:0] m;
  logic [4:0] c;
  logic [1:0] pads, hl, p, pinPair;
  scr_mode_type operatingMode;
  scr_pin_sources_type pinZeroSources = '0, pinOneSources = '0;
  int n_mismatch = 0, num_checks = 0, cycles = 0;
  logic [41:0] regRows [18] = '{{8'h10, 16'h0001, 2'b00, 16'h0001},
    {8'h10, 16'h0003, 2'b00, 16'h0001}, {8'h10, 16'h0000, 2'b00, 16'h0000},
    {8'h10, 16'h0002, 2'b00, 16'h0002}, {8'h11, 16'hF000, 2'b00, 16'h3000},
    {8'h11, 16'h2000, 2'b00, 16'h2000}, {8'h55, 16'hFFFF, 2'b00, 16'h0000},
    {8'h0D, 16'h04AD, 2'b00, 16'h04AD}, {8'h09, 16'hAD20, 2'b00, 16'h0020},
    {8'h09, 16'h0030, 2'b00, 16'h0020}, {8'h0D, 16'h44AD, 2'b00, 16'h44AD},
    {8'h09, 16'hAD40, 2'b01, 16'h0040}, {8'h09, 16'hAD50, 2'b10, 16'h0040},
    {8'h0D, 16'h84AD, 2'b00, 16'h84AD}, {8'h09, 16'hAD60, 2'b10, 16'h0060},
    {8'h0D, 16'hC4AD, 2'b00, 16'hC4AD}, {8'h09, 16'hAD10, 2'b01, 16'h0060},
    {8'h09, 16'hAD12, 2'b11, 16'h0012}};
  logic [15:0] pinRows [14] = '{{5'h00, 9'h100, 2'b10}, {5'h01, 9'h080, 2'b10},
    {5'h02, 9'h040, 2'b10}, {5'h05, 9'h020, 2'b10}, {5'h06, 9'h010, 2'b10},
    {5'h07, 9'h030, 2'b10}, {5'h07, 9'h020, 2'b11}, {5'h0C, 9'h008, 2'b10},
    {5'h0D, 9'h004, 2'b10}, {5'h0E, 9'h00C, 2'b10}, {5'h13, 9'h001, 2'b10},
    {5'h10, 9'h1FF, 2'b00}, {5'h11, 9'h000, 2'b11}, {5'h03, 9'h1FF, 2'b00}};
  scr_host_model scr_host_model_inst (.clock(clock), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
    .regReadData(regReadData));
  scr_control_regs scr_control_regs_inst (.clock(clock), .rst_n(rst_n),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWriteData(regWriteData), .regReadData(regReadData), .regWriteAck(regWriteAck),
    .regReadValid(regReadValid), .pinZeroSources(pinZeroSources),
    .pinOneSources(pinOneSources), .pinZeroPad(pinZeroPad), .pinOnePad(pinOnePad),
    .generalPinZero(generalPinZero), .generalPinOne(generalPinOne),
    .operatingMode(operatingMode), .extendedReadbackSelect(extendedReadbackSelect),
    .queueOverflowGuard(queueOverflowGuard), .busTargetAddress(busTargetAddress),
    .softResetActive(softResetActive));
  always #10 clock = ~clock;
  assign pinPair = {generalPinOne, generalPinZero};
  task automatic end_of_test();
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    // whole run needs well under a thousand cycles
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] ra, input logic [15:0] re);
    logic [15:0] rv;
    scr_host_model_inst.rd(ra, rv);
    check(rv, re);
  endtask
  task automatic waitPins(input logic [8:0] src);
    pinZeroSources = scr_pin_sources_type'(src);
    pinOneSources = scr_pin_sources_type'(src);
    repeat (2) @(posedge clock);
    #1;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    #1;
    rst_n = 1'b1;
    check({15'h0, queueOverflowGuard}, 16'h0001);
    rdc(ADDR_SLOT_FIFO, 16'h1000);
    rdc(ADDR_BUS_TARGET, 16'h00C8);
    foreach (regRows[i]) begin
      {a, d, pads, e} = regRows[i];
      {pinOnePad, pinZeroPad} = pads;
      scr_host_model_inst.wr(a, d);
      scr_host_model_inst.rd(a, r);
      check(r, e);
    end
    scr_host_model_inst.wr(ADDR_UNLOCK, 16'h1234);
    scr_host_model_inst.wr(ADDR_BUS_TARGET, 16'hAD22);
    rdc(ADDR_BUS_TARGET, 16'h0012);
    check({9'h000, busTargetAddress}, 16'h0009);
    foreach (pinRows[i]) begin
      {c, m, hl} = pinRows[i];
      scr_host_model_inst.wr(ADDR_PIN_ALT, {3'h0, c, 3'h0, c});
      waitPins(m);
      check(16'(pinPair), 16'({2{hl[1]}}));
      waitPins(~m);
      check(16'(pinPair), 16'({2{hl[0]}}));
    end
    scr_host_model_inst.wr(ADDR_PIN_ALT, {3'h0, SEL_TOGGLE, 3'h0, SEL_TOGGLE});
    waitPins(9'h000);
    repeat (2) begin
      p = {generalPinOne, generalPinZero};
      pinZeroSources.sampleTick = 1'b1;
      pinOneSources.sampleTick = 1'b1;
      @(posedge clock);
      #1;
      waitPins(9'h000);
      check({14'h0, generalPinOne, generalPinZero}, {14'h0, ~p});
    end
    scr_host_model_inst.wr(ADDR_SOFT_RESET, 16'h0001);
    rdc(ADDR_SOFT_RESET, 16'h0000);
    rdc(ADDR_MODE, 16'h0000);
    rdc(ADDR_SLOT_FIFO, 16'h1000);
    rdc(ADDR_BUS_TARGET, 16'h00C8);
    rdc(ADDR_UNLOCK, 16'h0000);
    rdc(ADDR_PIN_ALT, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
